// file: hw/dmb_device.sv
`timescale 1ns/100ps
// Notes on behaviour
// - 544 words on-chip RAM in three blocks
// - Two blocks always data; 256-word block switchable
// - Two commands map block to data/program
// - External program fetch works in either mapping
// - Decode program, data and I/O spaces
// - On-chip accesses finish with no wait
// - External access stalls until ready, then resumes
// - I/O uses same buses and cycle
// - Six registers mapped into data space
// - 8-bit allocation register sizes global region
// - Global operand raises bus request
// - Outside arbiter decides among sharing processors
// - Ready withheld until granted and done
// - Hold low floats bus, raises acknowledge
// - On-chip execution continues during hold
// - Interrupt waits for multicycle instruction end
// - Code copied to block runs on-chip
module dmb_device import dmb_pkg::*; #(
    parameter int ADDR_WIDTH = ADDR_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Core request port
    input wire logic req_valid,
    input wire dmb_space_t req_space,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic req_multicycle_active,
    output logic req_done,
    output logic [DATA_W-1:0] req_rdata,
    // Memory configuration commands
    input wire logic map_block_to_data,
    input wire logic map_block_to_program,
    output logic cfg_as_prog,
    // Interrupt gate
    input wire logic irq_pending,
    output logic irq_take,
    // Register views
    output logic [7:0] global_alloc_reg,
    output logic [DATA_W-1:0] serial_tx_word,
    output logic [DATA_W-1:0] timer_period_reg,
    output logic [DATA_W-1:0] int_mask,
    input wire logic [DATA_W-1:0] serial_rx_word,
    input wire logic [DATA_W-1:0] timer_count_reg,
    output logic in_hold,
    // External bus
    dmb_if.dev bus
);
    initial begin
        if (ADDR_WIDTH != ADDR_W) $error("dmb_device supports 16-bit addresses only");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_EXT, ST_HOLD} dmb_dev_state_t;

    logic [DATA_W-1:0] ram_q [RAM_TOTAL_WORDS];
    logic [1:0] ready_s_q, hold_s_q;
    dmb_dev_state_t st_q, st_d;
    logic cfg_q, cfg_d;
    logic [7:0] galloc_q, galloc_d;
    logic [DATA_W-1:0] tx_q, tx_d, prd_q, prd_d, imask_q, imask_d;
    logic done_q, done_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdo_q, wdo_d;
    logic oe_q, oe_d, ctrl_q, ctrl_d, strb_q, strb_d, rw_q, rw_d;
    logic [2:0] sel_q, sel_d;
    logic br_q, br_d, hack_q, hack_d;
    logic ready_in, hold_in;
    logic in_b0, in_b1, in_b2, is_reg, on_chip, is_global;
    logic [9:0] ram_idx;
    logic ram_we, take_on_chip;
    logic in_hold_q, in_hold_d;
    logic [DATA_W-1:0] reg_rd;

    assign ready_in = ready_s_q[1];
    assign hold_in = hold_s_q[1];

    // Address decode of the requested space
    always_comb begin
        in_b0 = 1'b0;
        in_b1 = 1'b0;
        in_b2 = 1'b0;
        is_reg = 1'b0;
        ram_idx = '0;
        reg_rd = '0;
        if (req_space == SP_DATA) begin
            in_b0 = !cfg_q && req_addr[15:8] == CFG_DATA_BASE[15:8];
            in_b1 = req_addr[15:8] == BLOCK_ONE_BASE[15:8];
            in_b2 = req_addr[15:5] == BLOCK_TWO_BASE[15:5];
            is_reg = req_addr[15:3] == 13'h0000 && req_addr[2:0] <= 3'h5;
        end else if (req_space == SP_PROG) begin
            in_b0 = cfg_q && req_addr[15:8] == CFG_PROG_BASE[15:8];
        end
        if (in_b0) ram_idx = {2'b00, req_addr[7:0]};
        else if (in_b1) ram_idx = 10'(CFG_BLOCK_WORDS) + {2'b00, req_addr[7:0]};
        else if (in_b2) ram_idx = 10'(CFG_BLOCK_WORDS + BLOCK_ONE_WORDS) + {5'h00, req_addr[4:0]};
        case (req_addr)
            SERIAL_RX_ADDR: reg_rd = serial_rx_word;
            SERIAL_TX_ADDR: reg_rd = tx_q;
            TIMER_COUNT_ADDR: reg_rd = timer_count_reg;
            TIMER_PERIOD_ADDR: reg_rd = prd_q;
            INT_MASK_ADDR: reg_rd = imask_q;
            GLOBAL_ALLOC_ADDR: reg_rd = {8'h00, galloc_q};
            default: reg_rd = '0;
        endcase
        on_chip = in_b0 || in_b1 || in_b2 || is_reg;
        // Global region is the top of data space, its size set by the allocation byte
        is_global = req_space == SP_DATA && !on_chip && galloc_q != 8'h00
            && req_addr[15:8] >= ~galloc_q;
    end

    // Same take condition for RAM and registers, in idle and in hold alike
    assign take_on_chip = req_valid && !done_q && on_chip
        && (st_q == ST_HOLD || (st_q == ST_IDLE && hold_in));
    assign ram_we = take_on_chip && req_write && !is_reg;

    always_comb begin
        st_d = st_q;
        cfg_d = cfg_q;
        galloc_d = galloc_q;
        tx_d = tx_q;
        prd_d = prd_q;
        imask_d = imask_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        addr_d = addr_q;
        wdo_d = wdo_q;
        oe_d = 1'b0;
        ctrl_d = ctrl_q;
        strb_d = 1'b1;
        rw_d = rw_q;
        sel_d = 3'b111;
        br_d = br_q;
        hack_d = hack_q;
        if (map_block_to_data) cfg_d = 1'b0;
        else if (map_block_to_program) cfg_d = 1'b1;
        if (take_on_chip && is_reg && req_write) begin
            case (req_addr)
                SERIAL_TX_ADDR: tx_d = req_wdata;
                TIMER_PERIOD_ADDR: prd_d = req_wdata;
                INT_MASK_ADDR: imask_d = req_wdata;
                GLOBAL_ALLOC_ADDR: galloc_d = req_wdata[7:0];
                default: ;
            endcase
        end
        irq_d = irq_pending && !req_multicycle_active && !(req_valid && !done_q);
        case (st_q)
            ST_IDLE: begin
                ctrl_d = 1'b1;
                hack_d = 1'b1;
                if (!hold_in) begin
                    st_d = ST_HOLD;
                    ctrl_d = 1'b0;
                    hack_d = 1'b0;
                    br_d = 1'b1;
                end else if (req_valid && !done_q) begin
                    if (on_chip) begin
                        done_d = 1'b1;
                        rdata_d = is_reg ? reg_rd : ram_q[ram_idx];
                    end else begin
                        st_d = ST_EXT;
                        addr_d = req_addr;
                        wdo_d = req_wdata;
                        rw_d = !req_write;
                        oe_d = req_write;
                        strb_d = 1'b0;
                        sel_d = req_space == SP_PROG ? 3'b110 :
                            (req_space == SP_DATA ? 3'b101 : 3'b011);
                        br_d = !is_global;
                    end
                end else begin
                    br_d = 1'b1;
                end
            end
            ST_EXT: begin
                oe_d = !rw_q;
                strb_d = 1'b0;
                sel_d = sel_q;
                if (ready_in) begin
                    st_d = ST_IDLE;
                    done_d = 1'b1;
                    rdata_d = bus.data_bus;
                    strb_d = 1'b1;
                    oe_d = 1'b0;
                    sel_d = 3'b111;
                end
            end
            ST_HOLD: begin
                ctrl_d = 1'b0;
                hack_d = 1'b0;
                // On-chip requests still served during hold
                if (take_on_chip) begin
                    done_d = 1'b1;
                    rdata_d = is_reg ? reg_rd : ram_q[ram_idx];
                end
                if (hold_in) begin
                    st_d = ST_IDLE;
                    hack_d = 1'b1;
                    ctrl_d = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        in_hold_d = !hack_d;
    end

    always_ff @(posedge mclk) begin
        if (ram_we) ram_q[ram_idx] <= req_wdata;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ready_s_q <= 2'b00;
            hold_s_q <= 2'b11;
            st_q <= ST_IDLE;
            cfg_q <= CFG_AS_PROG_RESET;
            galloc_q <= GLOBAL_ALLOC_RESET;
            tx_q <= '0;
            prd_q <= TIMER_PERIOD_RESET;
            imask_q <= INT_MASK_RESET;
            done_q <= 1'b0;
            rdata_q <= '0;
            irq_q <= 1'b0;
            addr_q <= '0;
            wdo_q <= '0;
            oe_q <= 1'b0;
            ctrl_q <= 1'b1;
            strb_q <= 1'b1;
            rw_q <= 1'b1;
            sel_q <= 3'b111;
            br_q <= 1'b1;
            hack_q <= 1'b1;
            in_hold_q <= 1'b0;
        end else begin
            ready_s_q <= {ready_s_q[0], bus.ready};
            hold_s_q <= {hold_s_q[0], bus.hold_n};
            st_q <= st_d;
            cfg_q <= cfg_d;
            galloc_q <= galloc_d;
            tx_q <= tx_d;
            prd_q <= prd_d;
            imask_q <= imask_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            addr_q <= addr_d;
            wdo_q <= wdo_d;
            oe_q <= oe_d;
            ctrl_q <= ctrl_d;
            strb_q <= strb_d;
            rw_q <= rw_d;
            sel_q <= sel_d;
            br_q <= br_d;
            hack_q <= hack_d;
            in_hold_q <= in_hold_d;
        end
    end

    assign req_done = done_q;
    assign req_rdata = rdata_q;
    assign cfg_as_prog = cfg_q;
    assign irq_take = irq_q;
    assign global_alloc_reg = galloc_q;
    assign serial_tx_word = tx_q;
    assign timer_period_reg = prd_q;
    assign int_mask = imask_q;
    assign in_hold = in_hold_q;
    assign bus.addr = addr_q;
    assign bus.data_dev = wdo_q;
    assign bus.data_dev_oe = oe_q;
    assign bus.ctrl_oe = ctrl_q;
    assign bus.strobe_n = strb_q;
    assign bus.rd_wr_n = rw_q;
    assign {bus.io_sel_n, bus.data_sel_n, bus.prog_sel_n} = sel_q;
    assign bus.bus_request_out_n = br_q;
    assign bus.hold_ack_out_n = hack_q;
endmodule

// file: common/dmb_pkg.sv
package dmb_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int CFG_BLOCK_WORDS = 256;
    localparam int BLOCK_ONE_WORDS = 256;
    localparam int BLOCK_TWO_WORDS = 32;
    localparam int RAM_TOTAL_WORDS = CFG_BLOCK_WORDS + BLOCK_ONE_WORDS + BLOCK_TWO_WORDS;
    // Data-space and program-space placement of the on-chip blocks
    localparam logic [15:0] CFG_DATA_BASE = 16'h0200;
    localparam logic [15:0] BLOCK_ONE_BASE = 16'h0300;
    localparam logic [15:0] BLOCK_TWO_BASE = 16'h0060;
    localparam logic [15:0] CFG_PROG_BASE = 16'hFF00;
    // Memory-mapped register addresses
    localparam logic [15:0] SERIAL_RX_ADDR = 16'h0000;
    localparam logic [15:0] SERIAL_TX_ADDR = 16'h0001;
    localparam logic [15:0] TIMER_COUNT_ADDR = 16'h0002;
    localparam logic [15:0] TIMER_PERIOD_ADDR = 16'h0003;
    localparam logic [15:0] INT_MASK_ADDR = 16'h0004;
    localparam logic [15:0] GLOBAL_ALLOC_ADDR = 16'h0005;
    localparam logic [7:0] GLOBAL_ALLOC_RESET = 8'h00;
    localparam logic [15:0] TIMER_PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] INT_MASK_RESET = 16'h0000;
    localparam logic CFG_AS_PROG_RESET = 1'b0;

    typedef enum logic [1:0] {SP_PROG, SP_DATA, SP_IO} dmb_space_t;
endpackage

// file: common/dmb_if.sv
`timescale 1ns/100ps
interface dmb_if;
    import dmb_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_dev;
    logic data_dev_oe;
    logic [DATA_W-1:0] data_ext;
    logic data_ext_oe;
    logic ctrl_oe;
    logic strobe_n;
    logic rd_wr_n;
    logic prog_sel_n;
    logic data_sel_n;
    logic io_sel_n;
    logic ready;
    logic bus_request_out_n;
    logic hold_n;
    logic hold_ack_out_n;
    wire [DATA_W-1:0] data_bus = data_dev_oe ? data_dev : (data_ext_oe ? data_ext : '0);

    modport dev (
        output addr, data_dev, data_dev_oe, ctrl_oe, strobe_n, rd_wr_n,
        output prog_sel_n, data_sel_n, io_sel_n, bus_request_out_n, hold_ack_out_n,
        input data_bus, ready, hold_n
    );
    modport ext (
        input addr, data_dev, data_dev_oe, ctrl_oe, strobe_n, rd_wr_n,
        input prog_sel_n, data_sel_n, io_sel_n, bus_request_out_n, hold_ack_out_n,
        output data_ext, data_ext_oe, ready, hold_n,
        input data_bus
    );
endinterface

// file: hw/dmb_external.sv
`timescale 1ns/100ps
module dmb_external import dmb_pkg::*; #(
    parameter int WAIT_CYCLES = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // User side
    input wire logic master_hold_req,
    input wire logic bus_granted,
    output logic holding,
    output logic access_seen,
    output logic [ADDR_W-1:0] last_addr,
    output logic [DATA_W-1:0] last_wdata,
    input wire logic [DATA_W-1:0] read_word,
    // Bus
    dmb_if.ext bus
);
    initial begin
        if (WAIT_CYCLES < 0 || WAIT_CYCLES > 255) $error("WAIT_CYCLES out of range");
    end

    logic [7:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, hold_q, hold_d, seen_q, seen_d, doe_q, doe_d;
    logic srv_q, srv_d, hld_q, hld_d;
    logic [ADDR_W-1:0] a_q, a_d;
    logic [DATA_W-1:0] w_q, w_d, rd_q, rd_d;

    always_comb begin
        cnt_d = cnt_q;
        rdy_d = 1'b0;
        seen_d = 1'b0;
        a_d = a_q;
        w_d = w_q;
        rd_d = read_word;
        doe_d = 1'b0;
        hold_d = !master_hold_req;
        srv_d = srv_q && !bus.strobe_n;
        hld_d = !bus.hold_ack_out_n;
        // One answer per strobe; read data stays up until the strobe ends
        if (!bus.strobe_n) begin
            doe_d = bus.rd_wr_n;
            // Global accesses wait for the grant
            if (!srv_q && (bus.bus_request_out_n || bus_granted)) begin
                if (cnt_q >= 8'(WAIT_CYCLES)) begin
                    rdy_d = 1'b1;
                    seen_d = 1'b1;
                    srv_d = 1'b1;
                    cnt_d = '0;
                    a_d = bus.addr;
                    w_d = bus.data_bus;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
            rdy_q <= 1'b0;
            hold_q <= 1'b1;
            seen_q <= 1'b0;
            doe_q <= 1'b0;
            a_q <= '0;
            w_q <= '0;
            rd_q <= '0;
            srv_q <= 1'b0;
            hld_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            hold_q <= hold_d;
            seen_q <= seen_d;
            doe_q <= doe_d;
            a_q <= a_d;
            w_q <= w_d;
            rd_q <= rd_d;
            srv_q <= srv_d;
            hld_q <= hld_d;
        end
    end

    assign bus.ready = rdy_q;
    assign bus.hold_n = hold_q;
    assign bus.data_ext = rd_q;
    assign bus.data_ext_oe = doe_q;
    assign holding = hld_q;
    assign access_seen = seen_q;
    assign last_addr = a_q;
    assign last_wdata = w_q;
endmodule

// file: test/dmb_chk.sv
`timescale 1ns/100ps
module dmb_chk import dmb_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Bus
    input wire logic [ADDR_W-1:0] addr,
    input wire logic data_dev_oe,
    input wire logic ctrl_oe,
    input wire logic strobe_n,
    input wire logic rd_wr_n,
    input wire logic prog_sel_n,
    input wire logic data_sel_n,
    input wire logic io_sel_n,
    input wire logic ready,
    input wire logic bus_request_out_n,
    input wire logic hold_n,
    input wire logic hold_ack_out_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // Two sync stages keep the acknowledge down after hold returns
    sequence s_ack_held;
        !hold_ack_out_n ##1 !hold_ack_out_n;
    endsequence
    property p_hold_release;
        $rose(hold_n) && !hold_ack_out_n |-> s_ack_held ##[1:3] hold_ack_out_n;
    endproperty
    property p_float;
        !hold_ack_out_n |-> !ctrl_oe && !data_dev_oe && strobe_n;
    endproperty
    property p_ack_cause;
        $fell(hold_ack_out_n) |-> !hold_n && !$past(hold_n);
    endproperty
    property p_ack_end;
        $rose(hold_ack_out_n) |-> hold_n && $past(hold_n) && $past(hold_n, 2);
    endproperty
    // Ready is seen two edges late through the sync flops
    property p_wait_ready;
        !strobe_n && !$past(ready, 2) |=> !strobe_n;
    endproperty
    property p_ready_done;
        !strobe_n && ready |-> ##[1:4] strobe_n;
    endproperty
    property p_one_space;
        !strobe_n |-> $onehot({!prog_sel_n, !data_sel_n, !io_sel_n});
    endproperty
    property p_stable_cycle;
        !strobe_n && !$past(strobe_n) |-> $stable(addr) && $stable(rd_wr_n)
            && $stable({prog_sel_n, data_sel_n, io_sel_n});
    endproperty
    property p_br_start;
        $fell(bus_request_out_n) |-> $fell(strobe_n) && !data_sel_n;
    endproperty
    property p_br_drop;
        strobe_n && $past(strobe_n) |-> bus_request_out_n;
    endproperty
    property p_write_drive;
        data_dev_oe |-> !rd_wr_n && ctrl_oe;
    endproperty

    a_hold_release: assert property (p_hold_release)
        else $error("hold acknowledge released at wrong time");
    a_float: assert property (p_float)
        else $error("bus driven while in hold");
    a_ack_cause: assert property (p_ack_cause)
        else $error("hold acknowledge without hold request");
    a_ack_end: assert property (p_ack_end)
        else $error("hold acknowledge dropped before hold high");
    a_wait_ready: assert property (p_wait_ready)
        else $error("strobe ended without ready");
    a_ready_done: assert property (p_ready_done)
        else $error("strobe not ended after ready");
    a_one_space: assert property (p_one_space)
        else $error("not exactly one space selected");
    a_stable_cycle: assert property (p_stable_cycle)
        else $error("address or control moved in cycle");
    a_br_start: assert property (p_br_start)
        else $error("bus request outside data strobe");
    a_br_drop: assert property (p_br_drop)
        else $error("bus request held in idle");
    a_write_drive: assert property (p_write_drive)
        else $error("data driven outside write");
endmodule

// file: test/test_dsp_memory_bus_interface.sv
`timescale 1ns/100ps
module test_dsp_memory_bus_interface;
    import dmb_pkg::*;
    localparam int WAIT_N = 3;
    localparam logic [15:0] RX = 16'hA5C3;
    localparam logic [15:0] CNT = 16'h0F0F;
    logic mclk, reset, req_valid, req_write, req_multicycle_active, irq_pending;
    logic map_block_to_data, map_block_to_program, master_hold_req, bus_granted;
    logic req_done, cfg_as_prog, irq_take, in_hold, holding, access_seen;
    dmb_space_t req_space;
    logic [15:0] req_addr, req_wdata, rdata, read_word, req_rdata, serial_tx_word;
    logic [15:0] timer_period_reg, int_mask, last_wdata, last_addr;
    logic [15:0] ram_a [7];
    logic [7:0] global_alloc_reg;
    logic br_seen;
    int error_cnt = 0;
    int n_tests = 0;
    int n_ext = 0;
    int cyc, e0;

    dmb_if i_dmb_if ();
    dmb_device i_dmb_device (.mclk, .reset, .req_valid, .req_space, .req_write, .req_addr,
        .req_wdata, .req_multicycle_active, .req_done, .req_rdata, .map_block_to_data,
        .map_block_to_program, .cfg_as_prog, .irq_pending, .irq_take, .global_alloc_reg,
        .serial_tx_word, .timer_period_reg, .int_mask, .serial_rx_word(RX),
        .timer_count_reg(CNT), .in_hold, .bus(i_dmb_if));
    dmb_external #(.WAIT_CYCLES(WAIT_N)) i_dmb_external (.mclk, .reset, .master_hold_req,
        .bus_granted, .holding, .access_seen, .last_addr, .last_wdata, .read_word,
        .bus(i_dmb_if));
    dmb_chk i_dmb_chk (.mclk, .reset, .addr(i_dmb_if.addr), .data_dev_oe(i_dmb_if.data_dev_oe),
        .ctrl_oe(i_dmb_if.ctrl_oe), .strobe_n(i_dmb_if.strobe_n), .rd_wr_n(i_dmb_if.rd_wr_n),
        .prog_sel_n(i_dmb_if.prog_sel_n), .data_sel_n(i_dmb_if.data_sel_n),
        .io_sel_n(i_dmb_if.io_sel_n), .ready(i_dmb_if.ready),
        .bus_request_out_n(i_dmb_if.bus_request_out_n), .hold_n(i_dmb_if.hold_n),
        .hold_ack_out_n(i_dmb_if.hold_ack_out_n));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (access_seen === 1'b1) n_ext <= n_ext + 1;
        if (i_dmb_if.bus_request_out_n === 1'b0) br_seen <= 1'b1;
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // Request held until done is seen, then dropped on the next edge
    task automatic access(input dmb_space_t sp, input logic wr, input logic [15:0] a, d);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_space <= sp;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        cyc = 0;
        do begin
            @(negedge mclk);
            cyc++;
        end while (req_done !== 1'b1 && cyc < 500);
        rdata = req_rdata;
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask

    task automatic finish_test;
        $display("Mismatches %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #60000;
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        reset = 1'b1;
        {req_valid, req_write, req_multicycle_active, irq_pending} = '0;
        {map_block_to_data, map_block_to_program, master_hold_req, br_seen} = '0;
        bus_granted = 1'b1;
        req_space = SP_DATA;
        {req_addr, req_wdata} = '0;
        read_word = 16'h3C3C;
        ram_a = '{CFG_DATA_BASE, CFG_DATA_BASE + 16'h00FF, BLOCK_ONE_BASE,
            BLOCK_ONE_BASE + 16'h001F, BLOCK_TWO_BASE, BLOCK_TWO_BASE + 16'h001F,
            BLOCK_ONE_BASE + 16'h0020};
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        chk_bit(cfg_as_prog, CFG_AS_PROG_RESET);
        chk_word({8'h00, global_alloc_reg}, {8'h00, GLOBAL_ALLOC_RESET});
        chk_word(timer_period_reg, TIMER_PERIOD_RESET);
        chk_word(int_mask, INT_MASK_RESET);
        chk_bit(i_dmb_if.hold_ack_out_n, 1'b1);
        access(SP_DATA, 1'b1, SERIAL_TX_ADDR, 16'h1234);
        chk_word(serial_tx_word, 16'h1234);
        access(SP_DATA, 1'b1, TIMER_PERIOD_ADDR, 16'h00C8);
        chk_word(timer_period_reg, 16'h00C8);
        access(SP_DATA, 1'b1, INT_MASK_ADDR, 16'h003F);
        chk_word(int_mask, 16'h003F);
        access(SP_DATA, 1'b1, GLOBAL_ALLOC_ADDR, 16'h0001);
        chk_word({8'h00, global_alloc_reg}, 16'h0001);
        access(SP_DATA, 1'b0, SERIAL_RX_ADDR, 16'h0000);
        chk_word(rdata, RX);
        access(SP_DATA, 1'b0, TIMER_COUNT_ADDR, 16'h0000);
        chk_word(rdata, CNT);
        for (int i = 0; i < 7; i++) begin
            access(SP_DATA, 1'b1, ram_a[i], 16'hC000 ^ ram_a[i]);
            chk_bit(cyc <= 3, 1'b1);
        end
        for (int i = 0; i < 7; i++) begin
            access(SP_DATA, 1'b0, ram_a[i], 16'h0000);
            chk_word(rdata, 16'hC000 ^ ram_a[i]);
        end
        chk_bit(n_ext == 0, 1'b1);
        @(posedge mclk) map_block_to_program <= 1'b1;
        @(posedge mclk) map_block_to_program <= 1'b0;
        @(negedge mclk) chk_bit(cfg_as_prog, 1'b1);
        access(SP_PROG, 1'b1, CFG_PROG_BASE + 16'h0010, 16'h7E57);
        access(SP_PROG, 1'b0, CFG_PROG_BASE + 16'h0010, 16'h0000);
        chk_word(rdata, 16'h7E57);
        chk_bit(n_ext == 0, 1'b1);
        access(SP_PROG, 1'b0, 16'h1000, 16'h0000);
        chk_word(rdata, read_word);
        chk_word(last_addr, 16'h1000);
        @(posedge mclk) map_block_to_data <= 1'b1;
        @(posedge mclk) map_block_to_data <= 1'b0;
        @(negedge mclk) chk_bit(cfg_as_prog, 1'b0);
        // Same cycle for every space; only the select differs
        for (int s = 0; s < 3; s++) begin
            access(dmb_space_t'(s), 1'b1, 16'h4100 + 16'(s), 16'h5A00 + 16'(s));
            chk_word(last_addr, 16'h4100 + 16'(s));
            chk_word(last_wdata, 16'h5A00 + 16'(s));
            chk_bit(cyc > WAIT_N + 3, 1'b1);
            access(dmb_space_t'(s), 1'b0, 16'h4100 + 16'(s), 16'h0000);
            chk_word(rdata, read_word);
        end
        chk_bit(br_seen, 1'b0);
        @(posedge mclk) bus_granted <= 1'b0;
        fork
            begin
                repeat (15) @(posedge mclk);
                bus_granted <= 1'b1;
            end
        join_none
        access(SP_DATA, 1'b0, 16'hFE10, 16'h0000);
        chk_bit(cyc > 15, 1'b1);
        chk_bit(br_seen, 1'b1);
        chk_word(rdata, read_word);
        repeat (3) @(negedge mclk);
        chk_bit(i_dmb_if.bus_request_out_n, 1'b1);
        @(posedge mclk) master_hold_req <= 1'b1;
        for (int i = 0; i < 20 && in_hold !== 1'b1; i++) @(negedge mclk);
        chk_bit(i_dmb_if.hold_ack_out_n, 1'b0);
        chk_bit(i_dmb_if.ctrl_oe, 1'b0);
        @(negedge mclk) chk_bit(holding, 1'b1);
        access(SP_DATA, 1'b0, BLOCK_ONE_BASE, 16'h0000);
        chk_word(rdata, 16'hC000 ^ BLOCK_ONE_BASE);
        access(SP_DATA, 1'b1, INT_MASK_ADDR, 16'h0015);
        chk_word(int_mask, 16'h0015);
        e0 = n_ext;
        fork
            access(SP_IO, 1'b0, 16'h0007, 16'h0000);
            begin
                repeat (12) @(negedge mclk);
                chk_bit(n_ext == e0, 1'b1);
                @(posedge mclk) master_hold_req <= 1'b0;
            end
        join
        chk_bit(cyc > 12, 1'b1);
        chk_word(rdata, read_word);
        chk_bit(i_dmb_if.hold_ack_out_n, 1'b1);
        @(posedge mclk) req_multicycle_active <= 1'b1;
        irq_pending <= 1'b1;
        repeat (5) @(negedge mclk);
        chk_bit(irq_take, 1'b0);
        @(posedge mclk) req_multicycle_active <= 1'b0;
        repeat (3) @(negedge mclk);
        chk_bit(irq_take, 1'b1);
        finish_test();
    end
endmodule
